// ===== bbg_pkg.sv
// package: mode encodings, selection bit positions and reset values for backup bus gating
package bbg_pkg;

	// ----------------------------------------
	// mode selection
	// ----------------------------------------
	localparam int SEL_W = 2;
	localparam int SEL_SWITCH_BIT = 0;
	localparam int SEL_SERIAL_BIT = 1;
	localparam logic [1:0] SEL_RESET = 2'h0;
	localparam int SYNC_STAGES = 2;

	typedef enum logic [1:0] {
		MODE_A = 2'h0,
		MODE_B = 2'h1,
		MODE_C = 2'h2,
		MODE_D = 2'h3
	} bbg_mode_type;

	typedef enum {
		PWR_MAIN,
		PWR_BACKUP
	} bbg_pwr_type;

endpackage : bbg_pkg

// ===== bbg_sync.sv
// two-flop synchroniser for a bundle of comparator flags
`timescale 1ns/1ps
module bbg_sync #(
	parameter int WIDTH = 3
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// flags
	input wire logic [WIDTH-1:0] flagIn,
	output logic [WIDTH-1:0] flagOut
);

	logic [WIDTH-1:0] stage1_q;
	logic [WIDTH-1:0] stage2_q;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge ref_clk or negedge reset_n) begin
				if (!reset_n) begin
					stage1_q[i] <= 1'b0;
					stage2_q[i] <= 1'b0;
				end else begin
					stage1_q[i] <= flagIn[i];
					stage2_q[i] <= stage1_q[i];
				end
			end
		end
	endgenerate

	assign flagOut = stage2_q;

endmodule : bbg_sync

// ===== bbg_gating.sv
// backup bus gating: switchover and serial/memory access decisions per mode
`timescale 1ns/1ps

// What this block does
// - below reset threshold, serial bus always silent
// - mode A: trip switchover, no backup access
// - mode A: serial works down to reset threshold
// - mode B: battery switchover, access when bat>main>reset
// - mode C behaves exactly like mode A
// - mode D: serial only above max(reset,battery)
// - irq/frequency output keeps running in backup
// - power-up default mode is standard, bits cleared
module bbg_gating (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// mode programming from the control register path
	input wire logic selWrite,
	input wire logic serial_in_backup_sel,
	input wire logic backup_switch_sel,
	// supply comparator flags
	input wire logic mainAboveResetThreshold,
	input wire logic mainAboveBattery,
	input wire logic mainAboveTripThreshold,
	// interrupt/frequency source from the clock core
	input wire logic irqFreqIn,
	// outputs
	output logic serialEnable,
	output logic memoryEnable,
	output logic onBattery,
	output logic low_voltage_reset,
	output logic irq_freq_output,
	output logic [1:0] modeSel
);

	// ----------------------------------------
	// flag synchronisation
	// ----------------------------------------
	logic [2:0] flagsRaw;
	logic [2:0] flagsSync;
	logic aboveReset;
	logic aboveBat;
	logic aboveTrip;

	assign flagsRaw = {mainAboveTripThreshold, mainAboveBattery, mainAboveResetThreshold};

	bbg_sync #(.WIDTH(3)) u_sync (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.flagIn(flagsRaw),
		.flagOut(flagsSync)
	);

	assign aboveReset = flagsSync[0];
	assign aboveBat = flagsSync[1];
	assign aboveTrip = flagsSync[2];

	// ----------------------------------------
	// mode selection
	// ----------------------------------------
	logic [1:0] sel_q;
	logic [1:0] sel_d;

	always_comb begin
		sel_d = sel_q;
		if (selWrite) begin
			sel_d[bbg_pkg::SEL_SERIAL_BIT] = serial_in_backup_sel;
			sel_d[bbg_pkg::SEL_SWITCH_BIT] = backup_switch_sel;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			sel_q <= bbg_pkg::SEL_RESET;
		end else begin
			sel_q <= sel_d;
		end
	end

	// ----------------------------------------
	// supply conditions
	// ----------------------------------------
	// each condition reads the synchronised flags only, so every decision
	// below sees one consistent snapshot of the comparators
	logic mainUsable;
	logic standardDrop;
	logic legacyDrop;
	logic mainAboveAll;

	assign mainUsable = aboveReset;
	assign standardDrop = !aboveTrip;
	assign legacyDrop = !aboveBat;
	assign mainAboveAll = aboveReset && aboveBat;

	// ----------------------------------------
	// mode decode
	// ----------------------------------------
	bbg_pkg::bbg_mode_type mode;
	logic legacyMode;
	logic backupNow;

	assign mode = bbg_pkg::bbg_mode_type'(sel_q);
	// legacy modes switch when main falls below battery, standard at trip
	assign legacyMode = sel_q[bbg_pkg::SEL_SWITCH_BIT];
	assign backupNow = legacyMode ? legacyDrop : standardDrop;

	// ----------------------------------------
	// per-mode access windows
	// ----------------------------------------
	// standard modes: serial bus and memory work on main power only;
	// main normally falls below the reset threshold before the trip point
	logic serialStd;
	logic memoryStd;
	// mode B: access carries on into backup while main is above reset
	logic serialLegacyOn;
	logic memoryLegacyOn;
	// mode D: serial only while main beats both reset threshold and battery
	logic serialLegacyOff;
	logic memoryLegacyOff;

	assign serialStd = mainUsable && !backupNow;
	assign memoryStd = mainUsable && !backupNow;
	assign serialLegacyOn = mainUsable;
	assign memoryLegacyOn = mainUsable;
	assign serialLegacyOff = mainAboveAll;
	assign memoryLegacyOff = mainUsable && !backupNow;

	// ----------------------------------------
	// access selection
	// ----------------------------------------
	logic serialNow;
	logic memoryNow;

	always_comb begin
		serialNow = 1'b0;
		memoryNow = 1'b0;
		case (mode)
			bbg_pkg::MODE_A, bbg_pkg::MODE_C: begin
				serialNow = serialStd;
				memoryNow = memoryStd;
			end
			bbg_pkg::MODE_B: begin
				serialNow = serialLegacyOn;
				memoryNow = memoryLegacyOn;
			end
			bbg_pkg::MODE_D: begin
				serialNow = serialLegacyOff;
				memoryNow = memoryLegacyOff;
			end
			default: begin
				serialNow = 1'b0;
				memoryNow = 1'b0;
			end
		endcase
	end

	// ----------------------------------------
	// power state
	// ----------------------------------------
	// follows the switchover decision; the next state feeds the output
	// flop directly so the state adds no cycle of its own
	bbg_pkg::bbg_pwr_type pwr_q;
	bbg_pkg::bbg_pwr_type pwr_d;
	logic onBatteryNext;

	always_comb begin
		pwr_d = pwr_q;
		case (pwr_q)
			bbg_pkg::PWR_MAIN: begin
				if (backupNow) begin
					pwr_d = bbg_pkg::PWR_BACKUP;
				end
			end
			bbg_pkg::PWR_BACKUP: begin
				if (!backupNow) begin
					pwr_d = bbg_pkg::PWR_MAIN;
				end
			end
			default: begin
				pwr_d = bbg_pkg::PWR_MAIN;
			end
		endcase
	end

	assign onBatteryNext = (pwr_d == bbg_pkg::PWR_BACKUP);

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			pwr_q <= bbg_pkg::PWR_MAIN;
		end else begin
			pwr_q <= pwr_d;
		end
	end

	// ----------------------------------------
	// registered outputs
	// ----------------------------------------
	// every output leaves from a flip-flop so the pins never glitch while
	// the decode settles; the serial enable is gated by the reset flag once
	// more so that no mode can keep the bus alive below reset threshold
	logic serial_q;
	logic memory_q;
	logic battery_q;
	logic lvr_q;
	logic irq_q;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			serial_q <= 1'b0;
			memory_q <= 1'b0;
			battery_q <= 1'b0;
			lvr_q <= 1'b1;
			irq_q <= 1'b1;
		end else begin
			serial_q <= serialNow && mainUsable;
			memory_q <= memoryNow;
			battery_q <= onBatteryNext;
			lvr_q <= !mainUsable;
			// irq/frequency path is never gated by the power state
			irq_q <= irqFreqIn;
		end
	end

	assign serialEnable = serial_q;
	assign memoryEnable = memory_q;
	assign onBattery = battery_q;
	assign low_voltage_reset = lvr_q;
	assign irq_freq_output = irq_q;
	assign modeSel = sel_q;

endmodule : bbg_gating

// ===== bbg_gating_assertions.sv
// checker: gating outputs against comparator flags and selected mode
`timescale 1ns/1ps
module bbg_chk (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// comparator flags and irq source
	input wire logic mainAboveResetThreshold,
	input wire logic mainAboveBattery,
	input wire logic mainAboveTripThreshold,
	input wire logic irqFreqIn,
	// gating outputs
	input wire logic serialEnable,
	input wire logic memoryEnable,
	input wire logic onBattery,
	input wire logic low_voltage_reset,
	input wire logic irq_freq_output,
	input wire logic [1:0] modeSel
);
	// {reset, battery, trip}
	logic [2:0] flagsNow;
	assign flagsNow = {mainAboveResetThreshold, mainAboveBattery, mainAboveTripThreshold};
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	sequence calm; $stable({flagsNow, modeSel}) [*3]; endsequence
	chk_lvr_gate: assert property ((!flagsNow[2]) [*3] |=> !serialEnable) else $error("serial on below reset");
	chk_lvr_flag: assert property (calm |=> low_voltage_reset == !$past(flagsNow[2])) else $error("lvr flag");
	chk_bat_state: assert property (calm |=> onBattery != $past(modeSel[0] ? flagsNow[1] : flagsNow[0]))
		else $error("battery state");
	// tag for the line above
	chk_std_access: assert property (calm ##0 !modeSel[0] |=> serialEnable == $past(flagsNow[2] && flagsNow[0])
		&& memoryEnable == $past(flagsNow[2] && flagsNow[0])) else $error("standard access");
	chk_b_access: assert property (calm ##0 modeSel == 2'h1 |=> serialEnable == $past(flagsNow[2])
		&& memoryEnable == $past(flagsNow[2])) else $error("mode b access");
	chk_d_use: assert property (calm ##0 modeSel == 2'h3 |=> serialEnable == $past(flagsNow[2] && flagsNow[1])
		&& memoryEnable == $past(flagsNow[2] && flagsNow[1])) else $error("mode d access");
	chk_irq_live: assert property (reset_n |=> irq_freq_output == $past(irqFreqIn)) else $error("irq gated");
endmodule : bbg_chk
bind bbg_gating bbg_chk i_bbg_chk (
	.ref_clk(ref_clk),
	.reset_n(reset_n),
	.mainAboveResetThreshold(mainAboveResetThreshold),
	.mainAboveBattery(mainAboveBattery),
	.mainAboveTripThreshold(mainAboveTripThreshold),
	.irqFreqIn(irqFreqIn),
	.serialEnable(serialEnable),
	.memoryEnable(memoryEnable),
	.onBattery(onBattery),
	.low_voltage_reset(low_voltage_reset),
	.irq_freq_output(irq_freq_output),
	.modeSel(modeSel)
);

// ===== bbg_host.sv
// host model
`timescale 1ns/1ps
module bbg_host (
	input wire logic ref_clk,
	output logic selWrite, serial_in_backup_sel, backup_switch_sel
);
	logic [2:0] drive = '0;
	assign {selWrite, serial_in_backup_sel, backup_switch_sel} = drive;
	// one strobe edge, then the bits show their inverse
	task automatic prog(input logic [1:0] m);
		@(posedge ref_clk) #2 drive = {1'b1, m};
		@(posedge ref_clk) #2 drive = {1'b0, ~m};
	endtask : prog
endmodule : bbg_host

// ===== backup_bus_gating_modes_bench.sv
// gating bench
`timescale 1ns/1ps
module backup_bus_gating_modes_bench;
	logic ref_clk = '0, reset_n = '0;
	logic [3:0] fl = '0;
	wire selWrite, serial_in_backup_sel, backup_switch_sel;
	wire [6:0] o;
	int err_total = 0, checks_done = 0, cyc = 0;
	logic [7:0] rows [8] = '{8'h3E, 8'h21, 8'hB1, 8'hBE, 8'h6F, 8'h41, 8'hE9, 8'hF6};
	always #12.5 ref_clk = ~ref_clk;
	bbg_host i_bbg_host (.ref_clk(ref_clk), .selWrite(selWrite), .serial_in_backup_sel(serial_in_backup_sel),
		.backup_switch_sel(backup_switch_sel));
	bbg_gating i_bbg_gating (.ref_clk(ref_clk), .reset_n(reset_n), .selWrite(selWrite),
		.serial_in_backup_sel(serial_in_backup_sel), .backup_switch_sel(backup_switch_sel),
		.mainAboveResetThreshold(fl[3]), .mainAboveBattery(fl[2]),
		.mainAboveTripThreshold(fl[1]), .irqFreqIn(fl[0]), .serialEnable(o[6]), .memoryEnable(o[5]),
		.onBattery(o[4]), .low_voltage_reset(o[3]), .irq_freq_output(o[2]), .modeSel(o[1:0]));
	task automatic chk(input logic [6:0] s, e);
		checks_done++;
		if (s !== e) begin
			err_total++;
			$display("BAD %0t %h %h", $time, s, e);
		end
	endtask : chk
	task automatic close_out;
		$display("checks %0d bad %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : close_out
	always @(posedge ref_clk) if (++cyc == 2000) begin
		err_total++;
		close_out();
	end
	initial begin
		repeat (16) @(posedge ref_clk);
		#2 chk(o, 7'h0C);
		$display("reset");
		reset_n = '1;
		foreach (rows[i]) begin
			i_bbg_host.prog(rows[i][7:6]);
			fl = {rows[i][5:3], i[0]};
			repeat (4) @(posedge ref_clk);
			#2 chk(o, {rows[i][2:0], !rows[i][5], i[0], rows[i][7:6]});
			$display("row %0d", i);
		end
		// serial drops exactly at the third edge after the reset flag falls
		i_bbg_host.prog(2'h3);
		fl = 4'hC;
		repeat (4) @(posedge ref_clk);
		#2 chk(o, 7'h63);
		fl = 4'h4;
		repeat (2) @(posedge ref_clk);
		#2 chk(o, 7'h63);
		@(posedge ref_clk);
		#2 chk(o, 7'h0B);
		$display("latency");
		// irq follows its source while on battery in mode B
		i_bbg_host.prog(2'h1);
		fl = 4'hA;
		repeat (4) @(posedge ref_clk);
		#2 chk(o, 7'h71);
		fl = 4'hB;
		@(posedge ref_clk);
		#2 chk(o, 7'h75);
		$display("irq");
		// reset in mid-run returns to mode A
		i_bbg_host.prog(2'h3);
		reset_n = '0;
		#1 chk(o, 7'h0C);
		repeat (2) @(posedge ref_clk);
		#2 reset_n = '1;
		fl = 4'hE;
		repeat (4) @(posedge ref_clk);
		#2 chk(o, 7'h60);
		$display("midreset");
		close_out();
	end
endmodule : backup_bus_gating_modes_bench
